// [logic/bsc_pkg.sv]
// constants, field layout and carrier types of the bridge secondary control
// assumes one 20 MHz clock that also paces the secondary bus cycles
package bsc_pkg;

  // ==========================================================================
  // register map, byte addresses on the apb port
  localparam logic [11:0] BSC_BRIDGE_CTRL_OFS = 12'h03c;
  localparam logic [11:0] BSC_AUX_CTRL_OFS    = 12'h040;

  // bridge control and interrupt register, bit positions
  localparam int BSC_DISCARD_ERR_MSG_ON_BIT  = 27;
  localparam int BSC_DISCARD_STATUS_BIT      = 26;
  localparam int BSC_SEC_DISCARD_SEL_BIT     = 25;
  localparam int BSC_PRI_DISCARD_SEL_BIT     = 24;
  localparam int BSC_FAST_B2B_ALLOW_BIT      = 23;
  localparam int BSC_SEC_RESET_BIT           = 22;
  localparam int BSC_MA_REPORT_MODE_BIT      = 21;
  localparam int BSC_VGA_FULL_DECODE_BIT     = 20;
  localparam int BSC_VGA_ENABLE_BIT          = 19;

  // auxiliary control register, bit positions
  localparam int BSC_CMD_SERR_EN_BIT         = 0;
  localparam int BSC_DISCARD_SEV_FATAL_BIT   = 1;
  localparam int BSC_MA_SEV_FATAL_BIT        = 2;

  // reset value of every stored field, fixed values of the read-only bits
  localparam logic BSC_FIELD_RST             = 1'b0;
  localparam logic BSC_PRI_DISCARD_SEL_VAL   = 1'b0;
  localparam logic BSC_FAST_B2B_ALLOW_VAL    = 1'b0;

  // ==========================================================================
  // discard interval lengths, in secondary clock cycles
  localparam int BSC_LONG_DISCARD_EXP  = 15;
  localparam int BSC_SHORT_DISCARD_EXP = 10;
  localparam int BSC_LONG_DISCARD_CYC  = 1 << BSC_LONG_DISCARD_EXP;
  localparam int BSC_SHORT_DISCARD_CYC = 1 << BSC_SHORT_DISCARD_EXP;

  // ==========================================================================
  // vga legacy i/o windows on the low ten address bits
  localparam logic [9:0] BSC_VGA_MONO_LO  = 10'h3b0;
  localparam logic [9:0] BSC_VGA_MONO_HI  = 10'h3bb;
  localparam logic [9:0] BSC_VGA_COLOR_LO = 10'h3c0;
  localparam logic [9:0] BSC_VGA_COLOR_HI = 10'h3df;

  // all-ones read data for unreported master aborts
  localparam logic [31:0] BSC_ALL_ONES = 32'hffff_ffff;

  // ==========================================================================
  // answer given to the secondary master for a non-posted completion
  typedef enum logic [1:0] {
    BSC_RESP_NONE   = 2'b00,
    BSC_RESP_NORMAL = 2'b01,
    BSC_RESP_ONES   = 2'b10,
    BSC_RESP_TABORT = 2'b11
  } bsc_resp_t;

  // discard timer states
  typedef enum logic {
    BSC_TMR_IDLE = 1'b0,
    BSC_TMR_RUN  = 1'b1
  } bsc_tmr_state_t;

  // ==========================================================================
  // software visible configuration
  typedef struct packed {
    logic discard_error_msg_on;
    logic discard_status;
    logic secondary_discard_interval_sel;
    logic sec_reset;
    logic master_abort_report_mode;
    logic vga_full_decode_sel;
    logic vga_enable;
    logic cmd_serr_en;
    logic discard_sev_fatal;
    logic ma_sev_fatal;
  } bsc_cfg_t;

  // apb answer
  typedef struct packed {
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } bsc_apb_rsp_t;

  // complete state of the top module
  typedef struct packed {
    bsc_cfg_t     cfg;
    bsc_apb_rsp_t apb;
    logic         dt_discard;
    logic         err_nonfatal;
    logic         err_fatal;
    bsc_resp_t    resp;
    logic [31:0]  resp_data;
    logic         pw_drop;
    logic         vga_fwd;
  } bsc_top_state_t;

  // complete state of the discard timer
  typedef struct packed {
    bsc_tmr_state_t state;
    logic [15:0]    cnt;
    logic           expire;
  } bsc_tmr_reg_t;

endpackage : bsc_pkg

// [logic/bsc_discard_timer.sv]
// discard counter for one delayed transaction
// assumes start and done are one-cycle pulses on the block clock
module bsc_discard_timer #(
  parameter int LONG_COUNT  = bsc_pkg::BSC_LONG_DISCARD_CYC,
  parameter int SHORT_COUNT = bsc_pkg::BSC_SHORT_DISCARD_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic flush,
  input  wire logic short_sel,
  input  wire logic start,
  input  wire logic done,
  output logic      expire,
  output logic      running
);

  // ==========================================================================
  // parameter check: counter is sixteen bits wide
  if (SHORT_COUNT < 2 || LONG_COUNT < 2 || LONG_COUNT > 65536 || SHORT_COUNT > 65536) begin : g_bad_count
    $error("discard counts must lie between 2 and 65536");
  end

  bsc_pkg::bsc_tmr_reg_t r;
  bsc_pkg::bsc_tmr_reg_t next_r;
  logic [15:0]           limit;

  // last count value before expiry, picked per interval select
  assign limit = short_sel ? 16'(SHORT_COUNT - 1) : 16'(LONG_COUNT - 1);

  // ==========================================================================
  // counter sequencing; flush beats done beats expiry beats start
  always_comb begin
    next_r        = r;
    next_r.expire = 1'b0;
    case (r.state)
      bsc_pkg::BSC_TMR_IDLE: begin
        if (start && !flush) begin
          next_r.state = bsc_pkg::BSC_TMR_RUN;
          next_r.cnt   = 16'h0000;
        end
      end
      bsc_pkg::BSC_TMR_RUN: begin
        if (flush || done) begin
          next_r.state = bsc_pkg::BSC_TMR_IDLE;
          next_r.cnt   = 16'h0000;
        end else if (r.cnt >= limit) begin
          next_r.state  = bsc_pkg::BSC_TMR_IDLE;
          next_r.cnt    = 16'h0000;
          next_r.expire = 1'b1;
        end else begin
          next_r.cnt = r.cnt + 16'h0001;
        end
      end
      default: begin
        next_r = '0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign expire  = r.expire;
  assign running = (r.state == bsc_pkg::BSC_TMR_RUN);

endmodule : bsc_discard_timer

// [logic/bsc_vga_decode.sv]
// vga legacy i/o address match, purely combinational
// assumes the caller registers the result
module bsc_vga_decode (
  input  wire logic [31:0] addr,
  input  wire logic        vga_enable,
  input  wire logic        full_sel,
  output logic             hit
);

  logic in_window;
  logic upper_ok;

  // ==========================================================================
  // legacy windows
  assign in_window = (addr[9:0] >= bsc_pkg::BSC_VGA_MONO_LO && addr[9:0] <= bsc_pkg::BSC_VGA_MONO_HI)
                  || (addr[9:0] >= bsc_pkg::BSC_VGA_COLOR_LO && addr[9:0] <= bsc_pkg::BSC_VGA_COLOR_HI);

  // decode width; ten-bit mode lets every 1 KB alias below 64 KB through
  assign upper_ok = (addr[31:16] == 16'h0000) && (!full_sel || addr[15:10] == 6'h00);

  assign hit = vga_enable && upper_ok && in_window;

endmodule : bsc_vga_decode

// [logic/bsc_top.sv]
// secondary-side control of the bridge: bridge control register over apb,
// discard timer, secondary reset, master-abort handling, vga i/o decode
// assumes the secondary bus runs on CLOCK and all inputs are synchronous to it
//
// Notes on behaviour
// - discard interval is 2^15 cycles with select 0, 2^10 with 1; resets 0.
// - discard counter starts when the completion reaches the queue head.
// - on expiry without a repeat, drop the transaction and set discard status.
// - primary discard select is read-only zero.
// - fast back-to-back enable is read-only zero.
// - secondary reset pin asserted while the reset field is 1; resets 0.
// - secondary reset returns secondary interface and buffering to default.
// - secondary reset leaves primary side and all registers untouched.
// - mode 0: unsupported request gives all-ones reads, i/o writes complete.
// - mode 0: master-aborted posted write is dropped silently.
// - mode 1: unsupported request answered with target-abort.
// - mode 1: aborted posted write sends error message if serr enabled.
// - fatal severity selectable only with advanced error reporting.
// - vga decode is 16-bit with select 1, 10-bit with aliases at 0.
// - vga decode width matters only while vga forwarding is on.
// - discard status set on discard, write 1 clears, resets 0.
// - discard error enable sends an error message upstream on discard.
// - vga i/o windows 0x3b0-0x3bb and 0x3c0-0x3df with upper bits zero.
module bsc_top #(
  parameter int LONG_COUNT  = bsc_pkg::BSC_LONG_DISCARD_CYC,
  parameter int SHORT_COUNT = bsc_pkg::BSC_SHORT_DISCARD_CYC,
  parameter bit AER_IMPL    = 1'b0
) (
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // secondary mode
  input  wire logic        PCI_MODE,
  // delayed transaction
  input  wire logic        DT_CPL_AT_HEAD,
  input  wire logic        DT_REPEAT_DONE,
  output logic             DT_DISCARD,
  // completion with unsupported request status
  input  wire logic        UR_CPL,
  input  wire logic        UR_CPL_IS_READ,
  output logic      [1:0]  SEC_RESP,
  output logic      [31:0] SEC_RESP_DATA,
  // master-aborted posted write
  input  wire logic        PW_MASTER_ABORT,
  output logic             PW_DROP,
  // upstream error messages
  output logic             ERR_NONFATAL_REQ,
  output logic             ERR_FATAL_REQ,
  // secondary reset
  output logic             SEC_PCI_RST,
  output logic             SEC_IF_INIT,
  // vga i/o decode
  input  wire logic        IO_REQ,
  input  wire logic [31:0] IO_ADDR,
  output logic             VGA_FWD
);

  bsc_pkg::bsc_top_state_t s;
  bsc_pkg::bsc_top_state_t next_s;
  logic                    tmr_expire;
  logic                    vga_hit;
  logic                    apb_setup;
  logic                    apb_commit;
  logic                    wr_ctrl;
  logic                    wr_aux;
  logic [31:0]             ctrl_word;
  logic [31:0]             aux_word;
  logic                    discard_event;
  logic                    ma_event;
  logic                    discard_fatal;
  logic                    ma_fatal;

  // ==========================================================================
  // sub-blocks

  bsc_discard_timer #(
    .LONG_COUNT  (LONG_COUNT),
    .SHORT_COUNT (SHORT_COUNT)
  ) u_discard_timer (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .flush     (s.cfg.sec_reset),
    .short_sel (s.cfg.secondary_discard_interval_sel),
    .start     (DT_CPL_AT_HEAD),
    .done      (DT_REPEAT_DONE),
    .expire    (tmr_expire),
    .running   ()
  );

  bsc_vga_decode u_vga_decode (
    .addr       (IO_ADDR),
    .vga_enable (s.cfg.vga_enable),
    .full_sel   (s.cfg.vga_full_decode_sel),
    .hit        (vga_hit)
  );

  // ==========================================================================
  // register read images

  always_comb begin
    ctrl_word                                       = 32'h0000_0000;
    ctrl_word[bsc_pkg::BSC_DISCARD_ERR_MSG_ON_BIT]  = s.cfg.discard_error_msg_on;
    ctrl_word[bsc_pkg::BSC_DISCARD_STATUS_BIT]      = s.cfg.discard_status;
    ctrl_word[bsc_pkg::BSC_SEC_DISCARD_SEL_BIT]     = s.cfg.secondary_discard_interval_sel;
    ctrl_word[bsc_pkg::BSC_PRI_DISCARD_SEL_BIT]     = bsc_pkg::BSC_PRI_DISCARD_SEL_VAL;
    ctrl_word[bsc_pkg::BSC_FAST_B2B_ALLOW_BIT]      = bsc_pkg::BSC_FAST_B2B_ALLOW_VAL;
    ctrl_word[bsc_pkg::BSC_SEC_RESET_BIT]           = s.cfg.sec_reset;
    ctrl_word[bsc_pkg::BSC_MA_REPORT_MODE_BIT]      = s.cfg.master_abort_report_mode;
    ctrl_word[bsc_pkg::BSC_VGA_FULL_DECODE_BIT]     = s.cfg.vga_full_decode_sel;
    ctrl_word[bsc_pkg::BSC_VGA_ENABLE_BIT]          = s.cfg.vga_enable;
    aux_word                                        = 32'h0000_0000;
    aux_word[bsc_pkg::BSC_CMD_SERR_EN_BIT]          = s.cfg.cmd_serr_en;
    aux_word[bsc_pkg::BSC_DISCARD_SEV_FATAL_BIT]    = s.cfg.discard_sev_fatal;
    aux_word[bsc_pkg::BSC_MA_SEV_FATAL_BIT]         = s.cfg.ma_sev_fatal;
  end

  // ==========================================================================
  // apb decode: answer prepared in setup, write lands in the access phase
  assign apb_setup  = PSEL && !PENABLE;
  assign apb_commit = PSEL && PENABLE && s.apb.ready && PWRITE;
  assign wr_ctrl    = apb_commit && (PADDR == bsc_pkg::BSC_BRIDGE_CTRL_OFS);
  assign wr_aux     = apb_commit && (PADDR == bsc_pkg::BSC_AUX_CTRL_OFS);

  // ==========================================================================
  // event qualification
  // discard on expiry
  assign discard_event = tmr_expire;
  // posted abort reported in mode 1
  assign ma_event = PW_MASTER_ABORT && s.cfg.master_abort_report_mode && s.cfg.cmd_serr_en
                 && !s.cfg.sec_reset;
  assign discard_fatal = AER_IMPL && s.cfg.discard_sev_fatal;
  assign ma_fatal      = AER_IMPL && s.cfg.ma_sev_fatal;

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;

    // apb answer, zero wait states; unmapped addresses answer slverr
    next_s.apb.ready  = apb_setup;
    next_s.apb.slverr = 1'b0;
    next_s.apb.rdata  = 32'h0000_0000;
    if (apb_setup) begin
      if (PADDR == bsc_pkg::BSC_BRIDGE_CTRL_OFS) begin
        next_s.apb.rdata = PWRITE ? 32'h0000_0000 : ctrl_word;
      end else if (PADDR == bsc_pkg::BSC_AUX_CTRL_OFS) begin
        next_s.apb.rdata = PWRITE ? 32'h0000_0000 : aux_word;
      end else begin
        next_s.apb.slverr = 1'b1;
      end
    end

    if (wr_ctrl) begin
      next_s.cfg.discard_error_msg_on           = PWDATA[bsc_pkg::BSC_DISCARD_ERR_MSG_ON_BIT];
      next_s.cfg.secondary_discard_interval_sel = PWDATA[bsc_pkg::BSC_SEC_DISCARD_SEL_BIT];
      next_s.cfg.sec_reset                      = PWDATA[bsc_pkg::BSC_SEC_RESET_BIT];
      next_s.cfg.master_abort_report_mode       = PWDATA[bsc_pkg::BSC_MA_REPORT_MODE_BIT];
      next_s.cfg.vga_full_decode_sel            = PWDATA[bsc_pkg::BSC_VGA_FULL_DECODE_BIT];
      next_s.cfg.vga_enable                     = PWDATA[bsc_pkg::BSC_VGA_ENABLE_BIT];
      if (PWDATA[bsc_pkg::BSC_DISCARD_STATUS_BIT]) begin
        next_s.cfg.discard_status = 1'b0;
      end
    end
    if (wr_aux) begin
      next_s.cfg.cmd_serr_en       = PWDATA[bsc_pkg::BSC_CMD_SERR_EN_BIT];
      next_s.cfg.discard_sev_fatal = PWDATA[bsc_pkg::BSC_DISCARD_SEV_FATAL_BIT];
      next_s.cfg.ma_sev_fatal      = PWDATA[bsc_pkg::BSC_MA_SEV_FATAL_BIT];
    end

    if (discard_event) begin
      next_s.cfg.discard_status = 1'b1;
    end

    next_s.dt_discard = discard_event;

    next_s.err_nonfatal = (discard_event && s.cfg.discard_error_msg_on && !discard_fatal)
                       || (ma_event && !ma_fatal);
    next_s.err_fatal    = (discard_event && s.cfg.discard_error_msg_on && discard_fatal)
                       || (ma_event && ma_fatal);

    next_s.pw_drop = PW_MASTER_ABORT && !s.cfg.master_abort_report_mode && !s.cfg.sec_reset;

    // answer to the secondary master for an unsupported request
    next_s.resp      = bsc_pkg::BSC_RESP_NONE;
    next_s.resp_data = 32'h0000_0000;
    if (UR_CPL && PCI_MODE && !s.cfg.sec_reset) begin
      if (s.cfg.master_abort_report_mode) begin
        next_s.resp = bsc_pkg::BSC_RESP_TABORT;
      end else if (UR_CPL_IS_READ) begin
        next_s.resp      = bsc_pkg::BSC_RESP_ONES;
        next_s.resp_data = bsc_pkg::BSC_ALL_ONES;
      end else begin
        next_s.resp = bsc_pkg::BSC_RESP_NORMAL;
      end
    end

    next_s.vga_fwd = IO_REQ && vga_hit;

    if (s.cfg.sec_reset) begin
      next_s.dt_discard = 1'b0;
      next_s.vga_fwd    = 1'b0;
    end
  end

  // ==========================================================================
  // state register; system reset only, secondary reset never clears config
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s     <= '0;
      s.cfg <= '{default: bsc_pkg::BSC_FIELD_RST};
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign PRDATA           = s.apb.rdata;
  assign PREADY           = s.apb.ready;
  assign PSLVERR          = s.apb.slverr;
  assign DT_DISCARD       = s.dt_discard;
  assign SEC_RESP         = s.resp;
  assign SEC_RESP_DATA    = s.resp_data;
  assign PW_DROP          = s.pw_drop;
  assign ERR_NONFATAL_REQ = s.err_nonfatal;
  assign ERR_FATAL_REQ    = s.err_fatal;
  assign SEC_PCI_RST      = s.cfg.sec_reset;
  assign SEC_IF_INIT      = s.cfg.sec_reset;
  assign VGA_FWD          = s.vga_fwd;

endmodule : bsc_top

// [verification/bsc_top_asserts.sv]
// checker of the secondary control block: apb, reset, abort, vga, discard
// assumes it is bound to bsc_top and sees its ports only
module bsc_top_asserts #(
  parameter bit AER_IMPL = 1'b0
) (
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PCI_MODE,
  input wire logic        UR_CPL,
  input wire logic        UR_CPL_IS_READ,
  input wire logic [1:0]  SEC_RESP,
  input wire logic [31:0] SEC_RESP_DATA,
  input wire logic        PW_MASTER_ABORT,
  input wire logic        PW_DROP,
  input wire logic        ERR_NONFATAL_REQ,
  input wire logic        ERR_FATAL_REQ,
  input wire logic        DT_DISCARD,
  input wire logic        SEC_PCI_RST,
  input wire logic        SEC_IF_INIT,
  input wire logic        IO_REQ,
  input wire logic [31:0] IO_ADDR,
  input wire logic        VGA_FWD
);
  // ==========================================================================
  // helper mirror of the control word
  logic [31:0] ctl;
  logic        wr_ctl;
  logic        hit;
  logic [9:0]  lo;
  assign wr_ctl = PSEL && PENABLE && PREADY && PWRITE && (PADDR == bsc_pkg::BSC_BRIDGE_CTRL_OFS);
  assign lo     = IO_ADDR[9:0];
  // legacy windows; aliases refused only with full decode
  assign hit = (IO_ADDR[31:16] == 16'h0000) && (!ctl[20] || IO_ADDR[15:10] == 6'h00) &&
               ((lo >= bsc_pkg::BSC_VGA_MONO_LO && lo <= bsc_pkg::BSC_VGA_MONO_HI) ||
                (lo >= bsc_pkg::BSC_VGA_COLOR_LO && lo <= bsc_pkg::BSC_VGA_COLOR_HI));
  // refreshed on each committed write, so bits 27, 25 and 22 to 19 match the field state
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctl <= 32'h0000_0000;
    end else if (wr_ctl) begin
      ctl <= PWDATA;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_ur_live;
    UR_CPL && PCI_MODE && !SEC_PCI_RST;
  endsequence
  property p_apb_ready;
    s_setup |=> PREADY;
  endproperty
  property p_ro_zero;
    PREADY && !PWRITE && PADDR == bsc_pkg::BSC_BRIDGE_CTRL_OFS |-> PRDATA[24:23] == 2'b00;
  endproperty
  property p_rst_pin;
    wr_ctl |=> SEC_PCI_RST == $past(PWDATA[22]);
  endproperty
  property p_rst_init;
    SEC_IF_INIT == SEC_PCI_RST;
  endproperty
  property p_ur_ones;
    s_ur_live ##0 (UR_CPL_IS_READ && !ctl[21]) |=> SEC_RESP == 2'b10 && SEC_RESP_DATA == bsc_pkg::BSC_ALL_ONES;
  endproperty
  property p_ur_iow;
    s_ur_live ##0 (!UR_CPL_IS_READ && !ctl[21]) |=> SEC_RESP == 2'b01;
  endproperty
  property p_ur_tabort;
    s_ur_live ##0 ctl[21] |=> SEC_RESP == 2'b11;
  endproperty
  property p_pw_drop;
    PW_MASTER_ABORT && !SEC_PCI_RST && !ctl[21] |=> PW_DROP;
  endproperty
  property p_no_fatal;
    !AER_IMPL |-> !ERR_FATAL_REQ;
  endproperty
  property p_vga_fwd;
    IO_REQ && ctl[19] && !SEC_PCI_RST |=> VGA_FWD == $past(hit);
  endproperty
  property p_vga_off;
    IO_REQ && !ctl[19] |=> !VGA_FWD;
  endproperty
  property p_discard_msg;
    DT_DISCARD && ctl[27] |-> ERR_NONFATAL_REQ || ERR_FATAL_REQ;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("apb setup not answered next cycle");
  a_ro_zero: assert property (p_ro_zero)
    else $error("read-only bits not zero");
  a_rst_pin: assert property (p_rst_pin)
    else $error("secondary reset pin differs from field");
  a_rst_init: assert property (p_rst_init)
    else $error("secondary init differs from reset pin");
  a_ur_ones: assert property (p_ur_ones)
    else $error("read abort not all ones");
  a_ur_iow: assert property (p_ur_iow)
    else $error("io write abort not completed");
  a_ur_tabort: assert property (p_ur_tabort)
    else $error("abort not target-abort");
  a_pw_drop: assert property (p_pw_drop)
    else $error("posted abort not dropped");
  a_no_fatal: assert property (p_no_fatal)
    else $error("fatal message without aer");
  a_vga_fwd: assert property (p_vga_fwd)
    else $error("vga forward wrong");
  a_vga_off: assert property (p_vga_off)
    else $error("vga forward while disabled");
  a_discard_msg: assert property (p_discard_msg)
    else $error("discard without message");
endmodule : bsc_top_asserts

bind bsc_top bsc_top_asserts #(.AER_IMPL(AER_IMPL)) u_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PCI_MODE(PCI_MODE), .UR_CPL(UR_CPL), .UR_CPL_IS_READ(UR_CPL_IS_READ), .SEC_RESP(SEC_RESP),
  .SEC_RESP_DATA(SEC_RESP_DATA), .PW_MASTER_ABORT(PW_MASTER_ABORT), .PW_DROP(PW_DROP),
  .ERR_NONFATAL_REQ(ERR_NONFATAL_REQ), .ERR_FATAL_REQ(ERR_FATAL_REQ), .DT_DISCARD(DT_DISCARD),
  .SEC_PCI_RST(SEC_PCI_RST), .SEC_IF_INIT(SEC_IF_INIT), .IO_REQ(IO_REQ), .IO_ADDR(IO_ADDR), .VGA_FWD(VGA_FWD));

// [verification/bsc_sec_master_model.sv]
// originating secondary master: repeats a delayed request after a delay
// assumes ask is a one-cycle pulse on the block clock
module bsc_sec_master_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ask,
  input  wire logic [7:0] delay,
  output logic            repeat_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic       busy;
  always_ff @(posedge clk) begin
    repeat_done <= 1'b0;
    if (rst) begin
      busy <= 1'b0;
    end else if (ask) begin
      busy <= 1'b1;
      left <= delay;
    end else if (busy && left == 8'h00) begin
      busy        <= 1'b0;
      repeat_done <= 1'b1;
    end else if (busy) begin
      left <= left - 8'h01;
    end
  end
endmodule : bsc_sec_master_model

// [verification/bsc_top_bench.sv]
// self-checking bench of the secondary control block
// assumes short discard counts so timer cases stay quick
module bsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          LONG_N  = 64;
  localparam int          SHORT_N = 16;
  localparam logic [11:0] CTL     = bsc_pkg::BSC_BRIDGE_CTRL_OFS;
  // {full decode, vga enable, address, forwarded}
  localparam logic [34:0] VT [8] = '{{2'b00, 32'h3b0, 1'b0}, {2'b01, 32'h3b0, 1'b1}, {2'b01, 32'h3bb, 1'b1},
    {2'b01, 32'h3bc, 1'b0}, {2'b01, 32'h7c0, 1'b1}, {2'b01, 32'h103df, 1'b0}, {2'b11, 32'h7c0, 1'b0},
    {2'b11, 32'h3df, 1'b1}};
  logic        clk, rst, psel, pen, pwr, pready, slv, pslverr, pmode, ur_rd, ask;
  logic        dt_done, disc, pw_drop, enf, ef, srst, sinit, vga;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, io_addr, resp_data;
  logic [3:0]  ev;
  logic [1:0]  resp;
  int          err_total, checked, n;

  bsc_top #(.LONG_COUNT(LONG_N), .SHORT_COUNT(SHORT_N), .AER_IMPL(1'b0)) dut (.CLOCK(clk), .SYS_RST(rst),
    .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PCI_MODE(pmode), .DT_CPL_AT_HEAD(ev[0]), .DT_REPEAT_DONE(dt_done), .DT_DISCARD(disc),
    .UR_CPL(ev[1]), .UR_CPL_IS_READ(ur_rd), .SEC_RESP(resp), .SEC_RESP_DATA(resp_data),
    .PW_MASTER_ABORT(ev[2]), .PW_DROP(pw_drop), .ERR_NONFATAL_REQ(enf), .ERR_FATAL_REQ(ef),
    .SEC_PCI_RST(srst), .SEC_IF_INIT(sinit), .IO_REQ(ev[3]), .IO_ADDR(io_addr), .VGA_FWD(vga));
  bsc_sec_master_model u_master (.clk(clk), .rst(rst), .ask(ask), .delay(8'd5), .repeat_done(dt_done));

  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; holds the request until pready is sampled high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // answer taken at the edge where pready stood high, released only then
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20) begin
      err_total++;
    end
    rd  = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  // one-cycle event pulses, outputs looked at one edge later
  task automatic fire(input logic [3:0] m, input logic r);
    @(posedge clk);
    ev  <= m;
    ask <= r;
    @(posedge clk);
    ev  <= 4'h0;
    ask <= 1'b0;
    #1;
  endtask : fire
  // start the discard counter and count cycles up to the discard
  task automatic dt_run(input int exp_n, input logic r, input logic msg);
    fire(4'h1, r);
    n = 0;
    while (disc !== 1'b1 && n < 2 * LONG_N) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n, exp_n);
    check(enf, msg);
  endtask : dt_run
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // about eighteen times the expected run length
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
  initial begin
    {rst, psel, pen, pwr, pmode, ur_rd, ask, ev, paddr, pwdata, io_addr} = '0;
    rst       = 1'b1;
    err_total = 0;
    checked   = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, CTL, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, CTL, 32'hffff_ffff);
    apb(1'b0, CTL, 32'h0);
    check(rd, 32'h0a78_0000);
    check({srst, sinit}, 2'b11);
    pmode <= 1'b1;
    fire(4'h2, 1'b0);
    check(resp, 2'b00);
    apb(1'b0, 12'h100, 32'h0);
    check(slv, 1'b1);
    check(rd, 32'h0);
    repeat (10) @(posedge clk);
    apb(1'b1, CTL, 32'h0);
    // write lands at the sampling edge; look one edge later
    @(posedge clk);
    check(srst, 1'b0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTL, {10'h0, i[1], 21'h0});
      ur_rd <= i[0];
      fire(4'h2, 1'b0);
      check(resp, i[1] ? 2'b11 : {i[0], !i[0]});
      check(resp_data, (!i[1] && i[0]) ? 32'hffff_ffff : 32'h0);
      fire(4'h4, 1'b0);
      check({pw_drop, enf}, {!i[1], 1'b0});
    end
    @(posedge clk);
    pmode <= 1'b0;
    fire(4'h2, 1'b0);
    check(resp, 2'b00);
    apb(1'b1, bsc_pkg::BSC_AUX_CTRL_OFS, 32'h5);
    fire(4'h4, 1'b0);
    check({enf, ef}, 2'b10);
    apb(1'b1, CTL, 32'h0a00_0000);
    // discard pulse is registered one edge after the counter expires
    dt_run(SHORT_N + 1, 1'b0, 1'b1);
    apb(1'b0, CTL, 32'h0);
    check(rd, 32'h0e00_0000);
    apb(1'b1, CTL, 32'h0400_0000);
    apb(1'b0, CTL, 32'h0);
    check(rd, 32'h0);
    dt_run(LONG_N + 1, 1'b0, 1'b0);
    dt_run(2 * LONG_N, 1'b1, 1'b0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CTL, {11'h0, VT[i][34:33], 19'h0});
      io_addr <= VT[i][32:1];
      fire(4'h8, 1'b0);
      check(vga, VT[i][0]);
    end
    report_and_stop();
  end
endmodule : bsc_top_bench
